// *** scc_pkg.sv ***
// scc_pkg: constants, encodings and carrier types of the conditioner control
package scc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS                 = 50;
	localparam int STARTUP_IF_NS          = 1000;
	localparam int STARTUP_MEASURE_NS     = 2000;
	localparam int WAKE_COMMAND_NS        = 500;
	localparam int WAKE_MEASURE_NS        = 1000;
	localparam int CALC_NS                = 1500;
	localparam logic [15:0] STARTUP_IF_CYC      =
		16'((STARTUP_IF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] STARTUP_MEASURE_CYC =
		16'((STARTUP_MEASURE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WAKE_COMMAND_CYC    =
		16'((WAKE_COMMAND_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WAKE_MEASURE_CYC    =
		16'((WAKE_MEASURE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CALC_CYC            =
		16'((CALC_NS + CLK_NS - 1) / CLK_NS);

	// ----------------------------------------------------------------
	// calibration memory
	// ----------------------------------------------------------------
	localparam int PAGES               = 4;
	localparam int WORDS               = 24;
	localparam logic [1:0] LAST_PAGE   = 2'h3;
	localparam logic [4:0] BM_CFG_ADDR = 5'h10;
	localparam int OFS_MSB             = 12;
	localparam int OFS_LSB             = 10;

	// ----------------------------------------------------------------
	// command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_READ_LAST  = 8'h17;
	localparam logic [7:0] OP_STAT_BASE  = 8'h20;
	localparam logic [7:0] OP_STAT_LAST  = 8'h37;
	localparam logic [7:0] OP_WRITE_BASE = 8'h40;
	localparam logic [7:0] OP_WRITE_LAST = 8'h57;
	localparam logic [7:0] OP_PAGE_INC   = 8'h5e;
	localparam logic [7:0] OP_ENTER_NORMAL  = 8'ha8;
	localparam logic [7:0] OP_ENTER_COMMAND = 8'ha9;
	localparam logic [7:0] OP_MEASURE    = 8'hac;
	localparam logic [3:0] OP_NOP_NIBBLE = 4'hf;

	// ----------------------------------------------------------------
	// status byte fields
	// ----------------------------------------------------------------
	localparam int ST_BUSY    = 6;
	localparam int ST_CMDMODE = 3;
	localparam int ST_FULL    = 2;
	localparam int ST_REFUSED = 0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MUX_GND, MUX_BRIDGE, MUX_TEMP} scc_mux_t;

	typedef enum logic [3:0] {
		BOOT, SLEEP, WAKE, ACTIVE, ZERO_BRIDGE_STEP, BRIDGE_STEP,
		ZERO_TEMP_STEP, TEMP_STEP, CALC
	} scc_state_t;

	typedef struct packed {
		logic [7:0]  op;
		logic [15:0] data;
	} scc_cmd_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] data;
	} scc_resp_t;

endpackage

// *** scc_link.sv ***
// scc_link: link-clock side, carries commands in and answers out
`timescale 1ns/1ns
`default_nettype none
module scc_link (
	input  wire logic              i_link_clk,
	input  wire logic              i_rst,
	input  wire logic              i_cmd_valid,
	input  wire scc_pkg::scc_cmd_t i_cmd,
	output logic                   o_cmd_tgl,
	output scc_pkg::scc_cmd_t      o_cmd,
	input  wire logic              i_resp_tgl,
	input  wire scc_pkg::scc_resp_t i_resp,
	output logic                   o_resp_valid,
	output scc_pkg::scc_resp_t     o_resp
);

	typedef struct packed {
		logic               rst_s1;
		logic               rst_s2;
		logic               cmd_tgl;
		scc_pkg::scc_cmd_t  cmd;
		logic               resp_s1;
		logic               resp_s2;
		logic               resp_s3;
		logic               resp_valid;
		scc_pkg::scc_resp_t resp;
	} scc_link_t;

	scc_link_t r;
	scc_link_t n;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// the link clock may stop between frames; a held command word and a
	// toggle survive that, a pulse would not
	always_comb begin
		n = r;
		n.rst_s1  = i_rst;
		n.rst_s2  = r.rst_s1;
		n.resp_s1 = i_resp_tgl;
		n.resp_s2 = r.resp_s1;
		n.resp_s3 = r.resp_s2;
		n.resp_valid = 1'b0;
		if (r.rst_s2) begin
			n.cmd_tgl = 1'b0;
			n.cmd     = '0;
			n.resp    = '0;
			n.resp_s3 = r.resp_s2;
		end else begin
			if (i_cmd_valid) begin
				n.cmd     = i_cmd;
				n.cmd_tgl = ~r.cmd_tgl;
			end
			if (r.resp_s2 != r.resp_s3) begin
				n.resp       = i_resp;
				n.resp_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge i_link_clk) begin
		r <= n;
	end

	assign o_cmd_tgl    = r.cmd_tgl;
	assign o_cmd        = r.cmd;
	assign o_resp_valid = r.resp_valid;
	assign o_resp       = r.resp;

endmodule // scc_link
`default_nettype wire

// *** scc_core.sv ***
// scc_core: mode control, measurement sequencing and calibration memory
// Overview of operation
// - converter offset code comes from bits 12:10 of config word 10h
// - code n applies offset (n+1)/16 of the reference
// - temperature steps use factory offset and gain, user segmentation
// - done pin rises only after conversion and calculation both finish
// - four one-time pages; host advances page and rewrites all content
// - user sees 24 words of 16 bits; factory area hidden
// - no erase, no way to clear programmed bits; here reset clears all memory pages
// - a write ORs the new value into the stored word
// - internal oscillator clocks the digital logic
// - supply supervision resets all digital logic
// - select pin 0 picks SPI, 1 picks I2C, default I2C
// - in sleep only the interface logic stays alive
// - startup delays before first command and first measurement
// - wake delays before further commands and before measuring
// - zero bridge step: bridge config, input at ground, 16-bit result
// - bridge step: bridge config, input at bridge pins, 16-bit result
// - temperature steps: temp config, ground then sensor, 16-bit results
// - measure command ACh runs the four steps then the correction
// - power-up reads config with core on, then core off into sleep
// - normal mode returns to sleep after measuring
// - command mode only if A9h is first command after reset
// - A9h enters command mode from normal, A8h leaves command mode
// - read at address, status at address+20h, write at address+40h
// - 5Eh advances the page pointer, command mode only
// - after four pages writes refused and memory-full reported
`timescale 1ns/1ns
`default_nettype none
module scc_core (
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	input  wire logic               i_link_clk,
	input  wire logic               i_cmd_valid,
	input  wire scc_pkg::scc_cmd_t  i_cmd,
	output logic                    o_resp_valid,
	output scc_pkg::scc_resp_t      o_resp,
	input  wire logic               i_if_sel_pin,
	output logic                    o_spi_mode,
	output logic                    o_core_domain_en,
	output logic                    o_adc_start,
	output scc_pkg::scc_mux_t       o_mux_sel,
	output logic                    o_use_factory_cfg,
	output logic [3:0]              o_adc_offset_num,
	input  wire logic               i_adc_done,
	input  wire logic [15:0]        i_adc_result,
	output logic                    o_conversion_done_pin,
	output logic [15:0]             o_bridge_out,
	output logic [15:0]             o_temp_out
);

	typedef struct packed {
		scc_pkg::scc_state_t st;
		logic [15:0]         cnt;
		logic [15:0]         boot_cnt;
		logic                boot_done;
		logic                sel_s1;
		logic                sel_s2;
		logic                cmd_s1;
		logic                cmd_s2;
		logic                cmd_s3;
		logic                first_seen;
		logic                cmd_mode;
		logic                meas_pend;
		logic [1:0]          page;
		logic                exhausted;
		logic [scc_pkg::PAGES-1:0][scc_pkg::WORDS-1:0][15:0] otp;
		logic [15:0]         res_zb;
		logic [15:0]         res_br;
		logic [15:0]         res_zt;
		logic [15:0]         res_tp;
		logic [15:0]         out_br;
		logic [15:0]         out_tp;
		logic                eoc;
		logic                adc_start;
		scc_pkg::scc_mux_t   mux;
		logic                factory;
		logic                core_en;
		logic                resp_tgl;
		scc_pkg::scc_resp_t  resp;
	} scc_core_t;

	scc_core_t r;
	scc_core_t n;

	logic               cmd_tgl;
	scc_pkg::scc_cmd_t  cmd;
	logic [4:0]         addr;
	logic [15:0]        cur_word;
	logic [15:0]        cfg_word;
	logic               send;
	logic               refused;
	logic [31:0]        sdata;
	logic               wr_acc;

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	scc_link u_link (
		.i_link_clk   (i_link_clk),
		.i_rst        (i_rst),
		.i_cmd_valid  (i_cmd_valid),
		.i_cmd        (i_cmd),
		.o_cmd_tgl    (cmd_tgl),
		.o_cmd        (cmd),
		.i_resp_tgl   (r.resp_tgl),
		.i_resp       (r.resp),
		.o_resp_valid (o_resp_valid),
		.o_resp       (o_resp)
	);

	assign addr     = cmd.op[4:0];
	assign cur_word = r.otp[r.page][addr];
	assign cfg_word = r.otp[r.page][scc_pkg::BM_CFG_ADDR];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		send    = 1'b0;
		refused = 1'b0;
		wr_acc  = 1'b0;
		sdata   = {r.out_br, r.out_tp};
		n.adc_start = 1'b0;
		n.sel_s1 = i_if_sel_pin;
		n.sel_s2 = r.sel_s1;
		n.cmd_s1 = cmd_tgl;
		n.cmd_s2 = r.cmd_s1;
		n.cmd_s3 = r.cmd_s2;
		if (!r.boot_done) begin
			if (r.boot_cnt == scc_pkg::STARTUP_MEASURE_CYC - 16'h1) begin
				n.boot_done = 1'b1;
			end else begin
				n.boot_cnt = r.boot_cnt + 16'h1;
			end
		end
		case (r.st)
			scc_pkg::BOOT: begin
				n.cnt = r.cnt + 16'h1;
				if (r.cnt == scc_pkg::STARTUP_IF_CYC - 16'h1) begin
					n.st  = scc_pkg::SLEEP;
					n.cnt = 16'h0;
				end
			end
			scc_pkg::WAKE: begin
				n.cnt = r.cnt + 16'h1;
				if (r.meas_pend) begin
					if (r.cnt >= scc_pkg::WAKE_MEASURE_CYC - 16'h1 &&
						r.boot_done) begin
						n.st        = scc_pkg::ZERO_BRIDGE_STEP;
						n.cnt       = 16'h0;
						n.meas_pend = 1'b0;
						n.eoc       = 1'b0;
					end
				end else if (r.cnt == scc_pkg::WAKE_COMMAND_CYC - 16'h1) begin
					n.st  = scc_pkg::ACTIVE;
					n.cnt = 16'h0;
				end
			end
			scc_pkg::ZERO_BRIDGE_STEP, scc_pkg::BRIDGE_STEP,
			scc_pkg::ZERO_TEMP_STEP, scc_pkg::TEMP_STEP: begin
				if (r.cnt == 16'h0) begin
					n.adc_start = 1'b1;
					n.cnt       = 16'h1;
				end else if (i_adc_done) begin
					n.cnt = 16'h0;
					case (r.st)
						scc_pkg::ZERO_BRIDGE_STEP: begin
							n.res_zb = i_adc_result;
							n.st     = scc_pkg::BRIDGE_STEP;
						end
						scc_pkg::BRIDGE_STEP: begin
							n.res_br = i_adc_result;
							n.st     = scc_pkg::ZERO_TEMP_STEP;
						end
						scc_pkg::ZERO_TEMP_STEP: begin
							n.res_zt = i_adc_result;
							n.st     = scc_pkg::TEMP_STEP;
						end
						default: begin
							n.res_tp = i_adc_result;
							n.st     = scc_pkg::CALC;
						end
					endcase
				end
			end
			scc_pkg::CALC: begin
				// stand-in correction: offset removal only, fixed latency
				n.cnt = r.cnt + 16'h1;
				if (r.cnt == scc_pkg::CALC_CYC - 16'h1) begin
					n.out_br = r.res_br - r.res_zb;
					n.out_tp = r.res_tp - r.res_zt;
					n.eoc    = 1'b1;
					n.cnt    = 16'h0;
					n.st     = r.cmd_mode ? scc_pkg::ACTIVE
						: scc_pkg::SLEEP;
					send  = 1'b1;
					sdata = {n.out_br, n.out_tp};
				end
			end
			scc_pkg::SLEEP, scc_pkg::ACTIVE: begin
			end
			default: begin
				n.st = scc_pkg::BOOT;
			end
		endcase

		// commands; the interface logic listens even in sleep
		if (r.cmd_s2 != r.cmd_s3 && r.st != scc_pkg::BOOT) begin
			if (r.st != scc_pkg::SLEEP && r.st != scc_pkg::ACTIVE) begin
				send    = 1'b1;
				refused = 1'b1;
			end else begin
				n.first_seen = 1'b1;
				send = 1'b1;
				if (cmd.op <= scc_pkg::OP_READ_LAST) begin
					sdata = {16'h0, cur_word};
				end else if (cmd.op >= scc_pkg::OP_STAT_BASE &&
					cmd.op <= scc_pkg::OP_STAT_LAST) begin
					sdata = {31'h0, cur_word != 16'h0};
				end else if (cmd.op >= scc_pkg::OP_WRITE_BASE &&
					cmd.op <= scc_pkg::OP_WRITE_LAST) begin
					if (r.cmd_mode && !r.exhausted) begin
						// or-only store: no command clears a bit
						n.otp[r.page][addr] = cur_word | cmd.data;
						wr_acc = 1'b1;
					end else begin
						refused = 1'b1;
					end
				end else if (cmd.op == scc_pkg::OP_PAGE_INC) begin
					if (!r.cmd_mode) begin
						refused = 1'b1;
					end else if (r.page == scc_pkg::LAST_PAGE) begin
						n.exhausted = 1'b1;
					end else begin
						n.page = r.page + 2'h1;
					end
				end else if (cmd.op == scc_pkg::OP_ENTER_COMMAND) begin
					if (!r.cmd_mode && !r.first_seen) begin
						n.cmd_mode  = 1'b1;
						n.meas_pend = 1'b0;
						n.st        = scc_pkg::WAKE;
						n.cnt       = 16'h0;
					end else begin
						refused = 1'b1;
					end
				end else if (cmd.op == scc_pkg::OP_ENTER_NORMAL) begin
					if (r.cmd_mode) begin
						n.cmd_mode = 1'b0;
						n.st       = scc_pkg::SLEEP;
					end else begin
						refused = 1'b1;
					end
				end else if (cmd.op == scc_pkg::OP_MEASURE) begin
					n.meas_pend = 1'b1;
					n.st        = scc_pkg::WAKE;
					n.cnt       = 16'h0;
					send        = 1'b0;
				end else if (cmd.op[7:4] == scc_pkg::OP_NOP_NIBBLE) begin
					sdata = {r.out_br, r.out_tp};
				end else begin
					refused = 1'b1;
				end
			end
		end

		case (n.st)
			scc_pkg::ZERO_BRIDGE_STEP, scc_pkg::ZERO_TEMP_STEP: begin
				n.mux = scc_pkg::MUX_GND;
			end
			scc_pkg::TEMP_STEP: begin
				n.mux = scc_pkg::MUX_TEMP;
			end
			default: begin
				n.mux = scc_pkg::MUX_BRIDGE;
			end
		endcase
		n.factory = (n.st == scc_pkg::ZERO_TEMP_STEP ||
			n.st == scc_pkg::TEMP_STEP);
		n.core_en = (n.st != scc_pkg::SLEEP);
		if (send) begin
			n.resp_tgl = ~r.resp_tgl;
			n.resp.data = sdata;
			n.resp.status = 8'h0;
			n.resp.status[scc_pkg::ST_BUSY] = (n.st != scc_pkg::SLEEP &&
				n.st != scc_pkg::ACTIVE);
			n.resp.status[scc_pkg::ST_CMDMODE] = n.cmd_mode;
			n.resp.status[scc_pkg::ST_FULL]    = n.exhausted;
			n.resp.status[scc_pkg::ST_REFUSED] = refused;
		end
	end

	// reset from supply supervision clears everything, memory included
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_spi_mode            = ~r.sel_s2;
	assign o_core_domain_en      = r.core_en;
	assign o_adc_start           = r.adc_start;
	assign o_mux_sel             = r.mux;
	assign o_use_factory_cfg     = r.factory;
	assign o_adc_offset_num      =
		{1'b0, cfg_word[scc_pkg::OFS_MSB:scc_pkg::OFS_LSB]} + 4'h1;
	assign o_conversion_done_pin = r.eoc;
	assign o_bridge_out          = r.out_br;
	assign o_temp_out            = r.out_tp;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_offset_step;
		@(posedge i_core_clk) disable iff (i_rst)
		o_adc_offset_num >= 4'h1 && o_adc_offset_num <= 4'h8 &&
		o_adc_offset_num[2:0] == cfg_word[11:10] + {cfg_word[12], 2'b0}
			+ 3'h1;
	endproperty
	a_offset_step: assert property (p_offset_step)
		else $error("offset step does not follow config code");

	property p_done_after_calc;
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_conversion_done_pin) |-> $past(r.st) == scc_pkg::CALC;
	endproperty
	a_done_after_calc: assert property (p_done_after_calc)
		else $error("done pin rose outside calculation end");

	property p_done_drops;
		@(posedge i_core_clk) disable iff (i_rst)
		r.st == scc_pkg::ZERO_BRIDGE_STEP |-> !o_conversion_done_pin;
	endproperty
	a_done_drops: assert property (p_done_drops)
		else $error("done pin still high in new sequence");

	property p_step_order;
		@(posedge i_core_clk) disable iff (i_rst)
		(r.st == scc_pkg::ZERO_BRIDGE_STEP ##1
			r.st != scc_pkg::ZERO_BRIDGE_STEP) |->
			r.st == scc_pkg::BRIDGE_STEP;
	endproperty
	a_step_order: assert property (p_step_order)
		else $error("bridge step did not follow zero step");

	property p_or_write;
		@(posedge i_core_clk) disable iff (i_rst)
		wr_acc |=> r.otp[$past(r.page)][$past(addr)] ==
			($past(cur_word) | $past(cmd.data));
	endproperty
	a_or_write: assert property (p_or_write)
		else $error("written word is not old or new");

	property p_no_clear;
		@(posedge i_core_clk) disable iff (i_rst)
		($past(cfg_word) & ~r.otp[$past(r.page)][scc_pkg::BM_CFG_ADDR])
			== 16'h0;
	endproperty
	a_no_clear: assert property (p_no_clear)
		else $error("a programmed bit was cleared");

	property p_full_refuse;
		@(posedge i_core_clk) disable iff (i_rst)
		(r.exhausted && r.cmd_s2 != r.cmd_s3 && r.st == scc_pkg::ACTIVE &&
			cmd.op >= scc_pkg::OP_WRITE_BASE &&
			cmd.op <= scc_pkg::OP_WRITE_LAST) |=>
			r.resp.status[scc_pkg::ST_FULL] && !$changed(r.otp);
	endproperty
	a_full_refuse: assert property (p_full_refuse)
		else $error("write after last page not refused");

	property p_sleep_core_off;
		@(posedge i_core_clk) disable iff (i_rst)
		r.st == scc_pkg::SLEEP |-> !o_core_domain_en && !o_adc_start;
	endproperty
	a_sleep_core_off: assert property (p_sleep_core_off)
		else $error("core active in sleep");

	property p_temp_factory;
		@(posedge i_core_clk) disable iff (i_rst)
		o_adc_start && o_mux_sel != scc_pkg::MUX_BRIDGE &&
		r.st != scc_pkg::ZERO_BRIDGE_STEP |-> o_use_factory_cfg;
	endproperty
	a_temp_factory: assert property (p_temp_factory)
		else $error("temperature step without factory setup");

	property p_first_command;
		@(posedge i_core_clk) disable iff (i_rst)
		$rose(r.cmd_mode) |-> !$past(r.first_seen);
	endproperty
	a_first_command: assert property (p_first_command)
		else $error("command mode entered late");

	property p_boot_core_on;
		@(posedge i_core_clk)
		(i_rst ##1 !i_rst) |=> o_core_domain_en;
	endproperty
	a_boot_core_on: assert property (p_boot_core_on)
		else $error("core off during power-up load");

endmodule // scc_core
`default_nettype wire

// *** scc_host.sv ***
// scc_host: link-side host model, one command at a time
`timescale 1ns/1ns
`default_nettype none
module scc_host (
	output logic                     o_link_clk,
	output logic                     o_cmd_valid,
	output scc_pkg::scc_cmd_t        o_cmd,
	input  wire logic                i_resp_valid,
	input  wire scc_pkg::scc_resp_t  i_resp
);
	logic raw_clk = 1'b0;
	logic run     = 1'b1;
	logic run_q   = 1'b1;
	bit   hung    = 1'b0;

	// ----------------------------------------------------------------
	// link clock
	// ----------------------------------------------------------------
	// gate changes only while low, so no runt pulses between frames
	always #40 raw_clk = ~raw_clk;
	always @(negedge raw_clk) run_q <= run;
	assign o_link_clk = raw_clk & run_q;

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd       = '0;
	end

	// ----------------------------------------------------------------
	// command frame
	// ----------------------------------------------------------------
	// next command only after the answer
	task automatic send(input logic [7:0] op, input logic [15:0] data,
		output scc_pkg::scc_resp_t resp);
		int n;
		run = 1'b1;
		repeat (2) @(posedge o_link_clk);
		#1 o_cmd_valid = 1'b1;
		o_cmd = {op, data};
		@(posedge o_link_clk);
		#1 o_cmd_valid = 1'b0;
		// released lines show the inverse, not a stale copy
		o_cmd = ~o_cmd;
		n = 0;
		do begin
			@(posedge o_link_clk);
			#1 n++;
		end while (i_resp_valid !== 1'b1 && n < 400);
		hung = (n >= 400);
		resp = i_resp;
		repeat (2) @(posedge o_link_clk);
		run = 1'b0;
	endtask
endmodule // scc_host
`default_nettype wire

// *** sensor_conditioner_control_tb_top.sv ***
// sensor_conditioner_control_tb_top: directed checks of the core
`timescale 1ns/1ns
`default_nettype none
module sensor_conditioner_control_tb_top;
	logic               core_clk = 1'b0;
	logic               rst      = 1'b1;
	logic               link_clk;
	logic               cmd_valid;
	scc_pkg::scc_cmd_t  cmd;
	logic               resp_valid;
	scc_pkg::scc_resp_t resp;
	scc_pkg::scc_resp_t r;
	logic               sel_pin  = 1'b1;
	logic               spi_mode;
	logic               dom_en;
	logic               adc_start;
	logic               fact;
	logic               done_pin;
	scc_pkg::scc_mux_t  mux;
	logic [3:0]         ofs_num;
	logic               adc_done = 1'b0;
	logic [15:0]        adc_res  = 16'h0;
	logic [15:0]        bridge_out;
	logic [15:0]        temp_out;
	logic [2:0]         steps[$];
	int                 fails       = 0;
	int                 check_count = 0;
	int                 cyc         = 0;

	always #25 core_clk = ~core_clk;

	scc_host i_host (
		.o_link_clk   (link_clk),
		.o_cmd_valid  (cmd_valid),
		.o_cmd        (cmd),
		.i_resp_valid (resp_valid),
		.i_resp       (resp)
	);

	scc_core i_dut (
		.i_core_clk            (core_clk),
		.i_rst                 (rst),
		.i_link_clk            (link_clk),
		.i_cmd_valid           (cmd_valid),
		.i_cmd                 (cmd),
		.o_resp_valid          (resp_valid),
		.o_resp                (resp),
		.i_if_sel_pin          (sel_pin),
		.o_spi_mode            (spi_mode),
		.o_core_domain_en      (dom_en),
		.o_adc_start           (adc_start),
		.o_mux_sel             (mux),
		.o_use_factory_cfg     (fact),
		.o_adc_offset_num      (ofs_num),
		.i_adc_done            (adc_done),
		.i_adc_result          (adc_res),
		.o_conversion_done_pin (done_pin),
		.o_bridge_out          (bridge_out),
		.o_temp_out            (temp_out)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmd_io(input logic [7:0] op, input logic [15:0] d);
		i_host.send(op, d, r);
		if (i_host.hung) begin
			fails++;
			close_out();
		end
	endtask

	// converter stand-in: distinct result per step, answers late
	always @(posedge core_clk) begin
		#1;
		if (adc_start === 1'b1) begin
			steps.push_back({fact, mux});
			chk(done_pin, 1'b0);
			adc_res = fact ? (mux == scc_pkg::MUX_TEMP ? 16'h0a40 : 16'h0040)
				: (mux == scc_pkg::MUX_BRIDGE ? 16'h1234 : 16'h0100);
			repeat (5) @(posedge core_clk);
			#1 adc_done = 1'b1;
			@(posedge core_clk);
			#1 adc_done = 1'b0;
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		#1;
		chk(ofs_num, 4'h1);
		rst = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		chk(dom_en, 1'b1);
		repeat (25) @(posedge core_clk);
		#1;
		chk(dom_en, 1'b0);
		chk(spi_mode, 1'b0);
		cmd_io(8'ha9, 16'h0);
		chk(r.status[3], 1'b1);
		chk(r.status[6], 1'b1);
		cmd_io(8'h50, 16'h1400);
		chk(r.status[0], 1'b0);
		cmd_io(8'h50, 16'h0021);
		cmd_io(8'h10, 16'h0);
		chk(r.data, 32'h1421);
		chk(ofs_num, 4'h6);
		cmd_io(8'h50, 16'h0001);
		cmd_io(8'h10, 16'h0);
		chk(r.data, 32'h1421);
		cmd_io(8'h30, 16'h0);
		chk(r.data[0], 1'b1);
		cmd_io(8'h31, 16'h0);
		chk(r.data[0], 1'b0);
		cmd_io(8'hac, 16'h0);
		chk(r.data, {16'h1134, 16'h0a00});
		chk(done_pin, 1'b1);
		chk(bridge_out, 16'h1134);
		chk(temp_out, 16'h0a00);
		chk(steps.size(), 4);
		chk({steps[0], steps[1], steps[2], steps[3]},
			{3'h0, 3'h1, 3'h4, 3'h6});
		chk(dom_en, 1'b1);
		cmd_io(8'hf0, 16'h0);
		chk(r.data, {16'h1134, 16'h0a00});
		cmd_io(8'h18, 16'h0);
		chk(r.status[0], 1'b1);
		cmd_io(8'h5e, 16'h0);
		cmd_io(8'h10, 16'h0);
		chk(r.data, 32'h0);
		cmd_io(8'h50, 16'h1c00);
		chk(ofs_num, 4'h8);
		repeat (3) cmd_io(8'h5e, 16'h0);
		cmd_io(8'h41, 16'hffff);
		chk({r.status[2], r.status[0]}, 2'h3);
		cmd_io(8'h01, 16'h0);
		chk(r.data, 32'h0);
		cmd_io(8'ha9, 16'h0);
		chk(r.status[0], 1'b1);
		cmd_io(8'ha8, 16'h0);
		chk(r.status[3], 1'b0);
		cmd_io(8'h42, 16'h0001);
		chk(r.status[0], 1'b1);
		cmd_io(8'h5e, 16'h0);
		chk(r.status[0], 1'b1);
		cmd_io(8'hac, 16'h0);
		repeat (5) @(posedge core_clk);
		#1;
		chk(dom_en, 1'b0);
		chk(done_pin, 1'b1);
		sel_pin = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		chk(spi_mode, 1'b1);
		close_out();
	end
endmodule // sensor_conditioner_control_tb_top
`default_nettype wire
